// ===== rtl/csc_defines.vh
// Constants for the card socket control block
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH
`define CSC_OP_MRD   2'h0
`define CSC_OP_MWR   2'h1
`define CSC_OP_IORD  2'h2
`define CSC_OP_IOWR  2'h3
`define CSC_SETUP_CYC  4'h2
`define CSC_STROBE_CYC 4'h4
`define CSC_HOLD_CYC   4'h2
`define CSC_CLKRUN_CYC 4'h4
`define CSC_ST_IDLE  3'h0
`define CSC_ST_SETUP 3'h1
`define CSC_ST_STRB  3'h2
`define CSC_ST_WAIT  3'h3
`define CSC_ST_HOLD  3'h4
`define CSC_CK_RUN   2'h0
`define CSC_CK_WARN  2'h1
`define CSC_CK_SLOW  2'h2
`define CSC_DIV_W    4
`endif

// ===== rtl/csc_slot.v
// One socket: 16-bit strobes, CardBus clock, clock-run and reset
`timescale 1ns/1ps
`include "csc_defines.vh"
module csc_slot #(
  parameter DIV_W = `CSC_DIV_W
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire             req,
  input  wire [1:0]       op,
  input  wire             attr,
  input  wire             cb_mode,
  input  wire             card_rst,
  input  wire             clk_slow,
  input  wire             clk_stop,
  input  wire [DIV_W-1:0] slow_div,
  input  wire             wait_n_raw,
  input  wire             wp_raw,
  input  wire             io_card,
  input  wire             vs1_raw,
  input  wire             vs2_raw,
  input  wire             clkrun_raw,
  input  wire             ccd_raw,
  output reg              busy,
  output reg              done,
  output reg              reg_n,
  output reg              oe_n,
  output reg              we_n,
  output reg              iord_n,
  output reg              iowr_n,
  output reg              reset,
  output reg              cclk,
  output reg              crst_n,
  output reg              clkrun_o,
  output reg              clkrun_oe,
  output reg              wp_stat,
  output reg              io16,
  output reg  [1:0]       vsense,
  output reg              clk_req
);
  // Two-stage synchronisers for all card-side inputs
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  always @(posedge clk) begin
    if (rst) begin
      s1_r <= 6'h3F;
      s2_r <= 6'h3F;
    end else if (ce) begin
      s1_r <= {ccd_raw, clkrun_raw, vs2_raw, vs1_raw, wp_raw, wait_n_raw};
      s2_r <= s1_r;
    end
  end
  wire wait_s   = ~s2_r[0];
  wire wp_s     = s2_r[1];
  wire clkrun_s = s2_r[4];

  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [3:0] cnt_r;
  reg [1:0] op_r;
  reg       attr_r;
  always @* begin
    st_nxt = st_r;
    case (st_r)
      `CSC_ST_IDLE:  if (req) st_nxt = `CSC_ST_SETUP;
      `CSC_ST_SETUP: if (cnt_r == `CSC_SETUP_CYC) st_nxt = `CSC_ST_STRB;
      `CSC_ST_STRB:  if (cnt_r == `CSC_STROBE_CYC) st_nxt = `CSC_ST_WAIT;
      `CSC_ST_WAIT:  if (!wait_s) st_nxt = `CSC_ST_HOLD;
      `CSC_ST_HOLD:  if (cnt_r == `CSC_HOLD_CYC) st_nxt = `CSC_ST_IDLE;
      default:       st_nxt = `CSC_ST_IDLE;
    endcase
  end

  wire strobe = (st_nxt == `CSC_ST_STRB) || (st_nxt == `CSC_ST_WAIT);
  always @(posedge clk) begin
    if (rst) begin
      st_r   <= `CSC_ST_IDLE;
      cnt_r  <= 4'h0;
      op_r   <= `CSC_OP_MRD;
      attr_r <= 1'b0;
      busy   <= 1'b0;
      done   <= 1'b0;
      reg_n  <= 1'b1;
      oe_n   <= 1'b1;
      we_n   <= 1'b1;
      iord_n <= 1'b1;
      iowr_n <= 1'b1;
      reset  <= 1'b1;
      wp_stat <= 1'b0;
      io16   <= 1'b0;
      vsense <= 2'h3;
    end else if (ce) begin
      st_r  <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 4'h1 : cnt_r + 4'h1;
      if (st_r == `CSC_ST_IDLE && req) begin
        op_r   <= op;
        // I/O strobes always use attribute select asserted
        attr_r <= attr | op[1];
      end
      busy <= (st_nxt != `CSC_ST_IDLE);
      done <= (st_r == `CSC_ST_HOLD) && (st_nxt == `CSC_ST_IDLE);
      // Select latched for setup..hold; high for common memory
      reg_n <= (st_nxt == `CSC_ST_IDLE) ? 1'b1 :
               (st_r == `CSC_ST_IDLE) ? ~(attr | op[1]) : ~attr_r;
      oe_n   <= ~(strobe && op_r == `CSC_OP_MRD);
      we_n   <= ~(strobe && op_r == `CSC_OP_MWR);
      iord_n <= ~(strobe && op_r == `CSC_OP_IORD);
      iowr_n <= ~(strobe && op_r == `CSC_OP_IOWR);
      reset  <= card_rst & ~cb_mode;
      wp_stat <= io_card ? 1'b0 : wp_s;
      io16    <= io_card ? ~wp_s : 1'b0;
      vsense  <= s2_r[3:2];
    end
  end

  // CardBus clock: full rate is half of CLK; slow mode divides further
  reg [DIV_W-1:0] div_r;
  reg [1:0]       ck_r;
  reg [3:0]       ckc_r;
  reg             crst_q_r;
  wire            want_slow = clk_slow | clk_stop;
  wire            tick = (ck_r != `CSC_CK_SLOW) || (div_r == slow_div);
  always @(posedge clk) begin
    if (rst) begin
      div_r <= {DIV_W{1'b0}};
      ck_r  <= `CSC_CK_RUN;
      ckc_r <= 4'h0;
      cclk  <= 1'b0;
      crst_n <= 1'b0;
      crst_q_r <= 1'b1;
      clkrun_o <= 1'b1;
      clkrun_oe <= 1'b0;
      clk_req <= 1'b0;
    end else if (ce) begin
      div_r <= tick ? {DIV_W{1'b0}} : div_r + 1'b1;
      case (ck_r)
        // A card holding clock-run low keeps the full rate
        `CSC_CK_RUN: if (want_slow && cb_mode && !crst_q_r &&
                         clkrun_s) begin
          ck_r  <= `CSC_CK_WARN;
          ckc_r <= 4'h0;
        end
        `CSC_CK_WARN: begin
          ckc_r <= ckc_r + 4'h1;
          if (ckc_r == `CSC_CLKRUN_CYC) ck_r <= `CSC_CK_SLOW;
        end
        `CSC_CK_SLOW: if (!want_slow || clkrun_s == 1'b0)
          ck_r <= `CSC_CK_RUN;
        default: ck_r <= `CSC_CK_RUN;
      endcase
      // Clock-run driven high to announce a decrease
      clkrun_oe <= (ck_r == `CSC_CK_WARN) || crst_q_r;
      clkrun_o  <= 1'b1;
      clk_req   <= (ck_r == `CSC_CK_SLOW) && !clkrun_s;
      if (!cb_mode || (ck_r == `CSC_CK_SLOW && clk_stop))
        cclk <= 1'b0;
      else if (tick)
        cclk <= ~cclk;
      // Assert at once, release only together with a rising edge
      crst_q_r <= card_rst | ~cb_mode;
      if (card_rst || !cb_mode)
        crst_n <= 1'b0;
      else if (tick && !cclk && !(ck_r == `CSC_CK_SLOW && clk_stop))
        crst_n <= 1'b1;
    end
  end
endmodule

// ===== rtl/csc_top.v
// Two independent card sockets
`timescale 1ns/1ps
`include "csc_defines.vh"
module csc_top #(
  parameter DIV_W = `CSC_DIV_W
) (
  input  wire             CLK,
  input  wire             SYS_RST,
  input  wire             CE,
  input  wire [1:0]       REQ,
  input  wire [3:0]       OP,
  input  wire [1:0]       ATTR,
  input  wire [1:0]       CB_MODE,
  input  wire [1:0]       CARD_RST,
  input  wire [1:0]       CLK_SLOW,
  input  wire [1:0]       CLK_STOP,
  input  wire [2*DIV_W-1:0] SLOW_DIV,
  input  wire [1:0]       IO_CARD,
  input  wire [1:0]       WAIT_N,
  input  wire [1:0]       WP_IN,
  input  wire [1:0]       VS1_IN,
  input  wire [1:0]       VS2_IN,
  input  wire [1:0]       CLKRUN_IN,
  input  wire [1:0]       CCD_IN,
  output wire [1:0]       BUSY,
  output wire [1:0]       DONE,
  output wire [1:0]       ATTR_SEL_N,
  output wire [1:0]       OE_N,
  output wire [1:0]       WE_N,
  output wire [1:0]       IORD_N,
  output wire [1:0]       IOWR_N,
  output wire [1:0]       CARD_RESET,
  output wire [1:0]       CB_CLK,
  output wire [1:0]       CB_RST_N,
  output wire [1:0]       CLKRUN_OUT,
  output wire [1:0]       CLKRUN_OE,
  output wire [1:0]       WP_STAT,
  output wire [1:0]       IO16,
  output wire [3:0]       VSENSE,
  output wire [1:0]       CLK_REQ
);
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : slot
      csc_slot #(.DIV_W(DIV_W)) u_slot (
        .clk        (CLK),
        .rst        (SYS_RST),
        .ce         (CE),
        .req        (REQ[g]),
        .op         (OP[2*g+1:2*g]),
        .attr       (ATTR[g]),
        .cb_mode    (CB_MODE[g]),
        .card_rst   (CARD_RST[g]),
        .clk_slow   (CLK_SLOW[g]),
        .clk_stop   (CLK_STOP[g]),
        .slow_div   (SLOW_DIV[DIV_W*g+DIV_W-1:DIV_W*g]),
        .wait_n_raw (WAIT_N[g]),
        .wp_raw     (WP_IN[g]),
        .io_card    (IO_CARD[g]),
        .vs1_raw    (VS1_IN[g]),
        .vs2_raw    (VS2_IN[g]),
        .clkrun_raw (CLKRUN_IN[g]),
        .ccd_raw    (CCD_IN[g]),
        .busy       (BUSY[g]),
        .done       (DONE[g]),
        .reg_n      (ATTR_SEL_N[g]),
        .oe_n       (OE_N[g]),
        .we_n       (WE_N[g]),
        .iord_n     (IORD_N[g]),
        .iowr_n     (IOWR_N[g]),
        .reset      (CARD_RESET[g]),
        .cclk       (CB_CLK[g]),
        .crst_n     (CB_RST_N[g]),
        .clkrun_o   (CLKRUN_OUT[g]),
        .clkrun_oe  (CLKRUN_OE[g]),
        .wp_stat    (WP_STAT[g]),
        .io16       (IO16[g]),
        .vsense     (VSENSE[2*g+1:2*g]),
        .clk_req    (CLK_REQ[g])
      );
    end
  endgenerate
endmodule

// ===== tb/csc_card.sv
// Card model for one socket
`timescale 1ns/1ps
module csc_card #(
  parameter VS = 2'h0
) (
  input  wire       clk, strb_n, io_card, wp_sw, port16, fast,
  input  wire [3:0] wcyc,
  input  wire       ck_out, ck_oe, crst_n,
  output reg        wait_n,
  output wire       wp, clkrun, ccd_n,
  output wire [1:0] vs
);
  reg [3:0] cnt = 0;
  reg       act = 0;
  always @(posedge clk) begin
    if (strb_n) begin
      act <= 1'b0;
    end else if (!act) begin
      act <= 1'b1;
      cnt <= wcyc;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  // Released wait line rests at its pull-up
  always @* wait_n = !(act && cnt != 0);
  assign wp = io_card ? !port16 : wp_sw;
  // Card floats in reset, so only the pull-up or the host drive shows
  assign clkrun = ck_oe ? ck_out : !(fast && crst_n);
  assign vs = VS;
  assign ccd_n = 1'b0;
endmodule

// ===== tb/csc_top_asserts.sv
// Pin protocol checks for the card sockets
`timescale 1ns/1ps
module csc_top_asserts (
  input wire       CLK,
  input wire       SYS_RST,
  input wire [1:0] ATTR, CB_MODE, CARD_RST, CLK_SLOW, CLK_STOP, IO_CARD,
  input wire [1:0] WAIT_N, WP_IN, DONE, BUSY, ATTR_SEL_N, OE_N, WE_N,
  input wire [1:0] IORD_N, IOWR_N, CARD_RESET, CB_CLK, CB_RST_N,
  input wire       CE,
  input wire [1:0] CLKRUN_OE, IO16, CLKRUN_IN
);
  wire s_n = &{OE_N[0], WE_N[0], IORD_N[0], IOWR_N[0]};
  // Stop waits out the clock-run warning and a card's hold request
  wire stop_ok = CB_MODE[0] && CLK_STOP[0] && CB_RST_N[0] && CLKRUN_IN[0];
  default clocking dc @(posedge CLK); endclocking
  // Frozen state is not checked
  default disable iff (SYS_RST || !CE);
  common_sel_a: assert property (!(OE_N[0] && WE_N[0]) && !ATTR[0] |->
    ATTR_SEL_N[0]) else $error("attr select low in common access");
  io_sel_a: assert property (!(IORD_N[0] && IOWR_N[0]) |->
    !ATTR_SEL_N[0]) else $error("io strobe without attr select");
  sel_stable_a: assert property (!s_n |-> $stable(ATTR_SEL_N[0]))
    else $error("attr select moved in strobe");
  wait_hold_a: assert property (!WAIT_N[0] [*3] ##0 !s_n |=> !s_n)
    else $error("strobe ended under wait");
  done_pulse_a: assert property (DONE[0] |-> !BUSY[0] ##1 !DONE[0])
    else $error("done not a single pulse");
  card_rst_a: assert property (CARD_RST[0] && !CB_MODE[0] |-> ##[1:3]
    CARD_RESET[0]) else $error("card reset missing");
  cb_rst_a: assert property (CARD_RST[0] && CB_MODE[0] |-> ##[1:3]
    !CB_RST_N[0]) else $error("cardbus reset missing");
  rst_rel_a: assert property ($rose(CB_RST_N[0]) && CB_MODE[0] |->
    $rose(CB_CLK[0])) else $error("reset released off clock edge");
  stop_low_a: assert property (stop_ok [*8] ##1 stop_ok [*3] |->
    !CB_CLK[0]) else $error("stopped card clock not low");
  warn_a: assert property ($rose(CLK_SLOW[0]) && CB_MODE[0] |->
    ##[1:4] CLKRUN_OE[0]) else $error("no clock-run warning");
  full_rate_a: assert property ((CB_MODE[0] && !CLK_SLOW[0] &&
    !CLK_STOP[0] && CB_RST_N[0]) [*6] |-> CB_CLK[0] != $past(CB_CLK[0]))
    else $error("card clock not at full rate");
  io16_a: assert property ((IO_CARD[1] && !WP_IN[1]) [*4] |-> IO16[1])
    else $error("port flag not shown");
  cover property (!WAIT_N[0] && !s_n);
  cover property ($rose(CLKRUN_OE[0]));
  cover property ($rose(CB_RST_N[0]));
endmodule

// ===== tb/test_csc_top.sv
// Self-checking bench for the two card sockets
`timescale 1ns/1ps
module test_csc_top;
  reg        CLK = 0, SYS_RST = 1, CE = 1;
  reg  [1:0] REQ = 0, ATTR = 0, CB_MODE = 0, CARD_RST = 0, CLK_SLOW = 0;
  reg  [1:0] CLK_STOP = 0, IO_CARD = 0, wps = 0, p16 = 0, fast = 0;
  reg  [3:0] OP = 0;
  reg  [7:0] SLOW_DIV = 8'h33, wcy = 0;
  wire [1:0] BUSY, DONE, ATTR_SEL_N, OE_N, WE_N, IORD_N, IOWR_N, CARD_RESET;
  wire [1:0] CB_CLK, CB_RST_N, CLKRUN_OUT, CLKRUN_OE, WP_STAT, IO16, CLK_REQ;
  wire [1:0] WAIT_N, WP_IN, VS1_IN, VS2_IN, CLKRUN_IN, CCD_IN;
  wire [3:0] VSENSE;
  integer    fails = 0, n_tests = 0;
  genvar     g;
  always #2.5 CLK = ~CLK;
  csc_top csc_top_i (.*);
  for (g = 0; g < 2; g = g + 1) begin : slot
    csc_card #(.VS(g + 1)) csc_card_i (.clk(CLK),
      .strb_n(&{OE_N[g], WE_N[g], IORD_N[g], IOWR_N[g]}),
      .io_card(IO_CARD[g]), .wp_sw(wps[g]), .port16(p16[g]),
      .fast(fast[g]), .wcyc(wcy[4*g +: 4]), .ck_out(CLKRUN_OUT[g]),
      .ck_oe(CLKRUN_OE[g]), .crst_n(CB_RST_N[g]), .wait_n(WAIT_N[g]),
      .wp(WP_IN[g]), .clkrun(CLKRUN_IN[g]), .ccd_n(CCD_IN[g]),
      .vs({VS2_IN[g], VS1_IN[g]}));
  end
  task complete_run;
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge CLK);
  endtask
  task tog(input integer m, output integer n);
    integer k;
    reg     p;
    begin
      n = 0;
      p = CB_CLK[0];
      for (k = 0; k < m; k = k + 1) begin
        @(negedge CLK);
        n = n + (CB_CLK[0] !== p);
        p = CB_CLK[0];
      end
    end
  endtask
  task t_acc(input integer s, input [1:0] o, input a, input [3:0] w);
    integer k, len;
    reg [3:0] st;
    reg       sel;
    begin
      OP[2*s +: 2] = o;
      ATTR[s] = a;
      wcy[4*s +: 4] = w;
      REQ[s] = 1;
      @(negedge CLK) REQ[s] = 0;
      chk(BUSY[s], 1);
      len = 0;
      st = 4'hF;
      sel = 1;
      for (k = 0; k < 60 && DONE[s] !== 1'b1; k = k + 1) begin
        if ({IOWR_N[s], IORD_N[s], WE_N[s], OE_N[s]} !== 4'hF) begin
          len = len + 1;
          st = {IOWR_N[s], IORD_N[s], WE_N[s], OE_N[s]};
          sel = ATTR_SEL_N[s];
        end
        @(negedge CLK);
      end
      if (k == 60) begin
        fails = fails + 1;
        complete_run;
      end
      chk(st, 4'hF ^ (4'h1 << o));
      chk(sel, !(a || o[1]));
      chk(len >= 4 && len >= w + 2, 1);
    end
  endtask
  task t_card;
    wps = 2'h1;
    IO_CARD = 2'h2;
    p16 = 2'h2;
    cyc(6);
    chk(WP_STAT[0], 1);
    chk(IO16, 2'h2);
    chk(VSENSE, 4'h9);
  endtask
  task t_rst16;
    CE = 0;
    CARD_RST = 2'h3;
    cyc(4);
    chk(CARD_RESET, 2'h0);
    CE = 1;
    cyc(4);
    chk(CARD_RESET, 2'h3);
    CARD_RST = 0;
    cyc(4);
    chk(CARD_RESET, 2'h0);
  endtask
  task t_cb;
    integer k, n;
    reg     s;
    begin
      CB_MODE = 2'h1;
      CARD_RST = 2'h1;
      cyc(3);
      chk(CB_RST_N[0], 0);
      chk(CARD_RESET[1], 0);
      CARD_RST = 0;
      cyc(8);
      chk(CB_RST_N[0], 1);
      tog(8, n);
      chk(n, 8);
      CLK_SLOW = 2'h1;
      s = 0;
      for (k = 0; k < 8; k = k + 1) begin
        @(negedge CLK);
        s = s | CLKRUN_OE[0];
      end
      chk(s, 1);
      cyc(4);
      chk(CLKRUN_OE[0], 0);
      tog(16, n);
      chk(n, 4);
      fast = 2'h1;
      s = 0;
      for (k = 0; k < 6; k = k + 1) begin
        @(negedge CLK);
        s = s | CLK_REQ[0];
      end
      chk(s, 1);
      tog(8, n);
      chk(n, 8);
      fast = 0;
      CLK_STOP = 2'h1;
      cyc(10);
      tog(8, n);
      chk(n, 0);
      chk(CB_CLK[0], 0);
    end
  endtask
  initial begin
    cyc(12);
    SYS_RST = 0;
    cyc(2);
    t_acc(0, 2'h0, 1'b0, 4'h0);
    t_acc(0, 2'h1, 1'b1, 4'h0);
    t_acc(0, 2'h2, 1'b0, 4'h0);
    t_acc(0, 2'h3, 1'b0, 4'h6);
    t_acc(1, 2'h0, 1'b1, 4'h2);
    t_card;
    t_rst16;
    t_cb;
    complete_run;
  end
endmodule
bind csc_top csc_top_asserts csc_top_asserts_i (.*);
